// *** core/ctp_consts.svh ***
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// Register byte offsets on the APB window
`define CTP_OFF_LCTRL 8'h00
`define CTP_OFF_UCTRL 8'h04
`define CTP_OFF_LCNT  8'h08
`define CTP_OFF_UCNT  8'h0C
`define CTP_OFF_LPER  8'h10
`define CTP_OFF_UPER  8'h14
`define CTP_OFF_STAT  8'h18
`define CTP_OFF_MASK  8'h1C

// Control register field positions
`define CTP_BIT_RUN   15
`define CTP_BIT_IDLE  13
`define CTP_BIT_GATE  6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_PAIR  3
`define CTP_BIT_CSS   1

// Implemented control bits; everything else reads zero
`define CTP_LCTRL_MASK 16'hA07A
`define CTP_UCTRL_MASK 16'hA072

// Status and mask bit positions
`define CTP_IRQ_LOWER 0
`define CTP_IRQ_UPPER 1

// Reset values and the counter maximum
`define CTP_CTRL_RST   16'h0000
`define CTP_PERIOD_RST 16'hFFFF
`define CTP_CNT_MAX    16'hFFFF

// Prescaler terminal counts (divide ratio minus one)
`define CTP_TERM_1   8'h00
`define CTP_TERM_8   8'h07
`define CTP_TERM_64  8'h3F
`define CTP_TERM_256 8'hFF

`endif

// *** core/ctp_pkg.sv ***
package ctp_pkg;

    // Prescale select codes
    typedef enum logic [1:0] {
        CTP_PS_1   = 2'h0,
        CTP_PS_8   = 2'h1,
        CTP_PS_64  = 2'h2,
        CTP_PS_256 = 2'h3
    } ctp_presc_t;

endpackage

// *** core/ctp_tick_if.sv ***
`timescale 1ns/10ps
interface ctp_tick_if;
    logic                active;
    logic                css;
    logic                gate_en;
    logic                gate;
    logic                ext_pin;
    ctp_pkg::ctp_presc_t presc;
    logic                tick;

    modport ctl (output active, css, gate_en, gate, ext_pin, presc, input tick);
    modport pre (input active, css, gate_en, gate, ext_pin, presc, output tick);
endinterface

// *** core/ctp_prescaler.sv ***
`timescale 1ns/10ps
`include "ctp_consts.svh"
module ctp_prescaler (
    // Clock and reset
    input logic     pclk,
    input logic     presetn,
    // Timer input configuration and tick
    ctp_tick_if.pre tk
);
    logic       ext_prev_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // Input event: pin rising edge, or peripheral clock qualified by gate
    wire ext_rise = tk.ext_pin & ~ext_prev_r;                          // [RULE_08]
    wire in_evt   = tk.css ? ext_rise : (~tk.gate_en | tk.gate);       // [RULE_03] [RULE_04]
    wire [7:0] term = (tk.presc == ctp_pkg::CTP_PS_256) ? `CTP_TERM_256 :
                      (tk.presc == ctp_pkg::CTP_PS_64)  ? `CTP_TERM_64  :
                      (tk.presc == ctp_pkg::CTP_PS_8)   ? `CTP_TERM_8   :
                                                          `CTP_TERM_1;  // [RULE_05]
    wire at_term = (cnt_r == term);

    assign tk.tick = tk.active & in_evt & at_term;
    // Stopped timer clears the divider so a restart gives a full first period
    assign cnt_nxt = !tk.active ? 8'h00 :
                     !in_evt    ? cnt_r :
                     at_term    ? 8'h00 : 8'(cnt_r + 8'h01);

    // Divider and pin history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r      <= 8'h00;
            ext_prev_r <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            ext_prev_r <= tk.ext_pin;
        end
    end

    a_div_eight: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
        ($rose(tk.active) && !tk.css && !tk.gate_en && tk.presc == ctp_pkg::CTP_PS_8)
        ##1 (tk.active && !tk.css && !tk.gate_en && tk.presc == ctp_pkg::CTP_PS_8)[*7]
        |-> tk.tick) else $error("divide by 8 tick not on eighth clock");
endmodule // ctp_prescaler

// *** core/ctp_counter.sv ***
`timescale 1ns/10ps
module ctp_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input  logic         pclk,
    input  logic         presetn,
    // Count control
    input  logic         inc,
    input  logic         clr,
    input  logic         wr_en,
    input  logic [W-1:0] wr_data,
    // Count value
    output logic [W-1:0] count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // Software write beats period clear, clear beats increment
    assign count_nxt = wr_en ? wr_data :
                       clr   ? '0      :
                       inc   ? W'(count_r + 1'b1) : count_r; // [RULE_14]
    assign count = count_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    a_clr_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        (clr && !wr_en) |=> (count_r == '0)) else $error("count not cleared on match");
endmodule // ctp_counter

// *** core/ctp_top.sv ***
// Contract
// [RULE_01] The lower run bit starts and stops the lower timer, or the whole pair in pair mode.
// [RULE_02] A set idle-halt bit stops its timer while the device is idle; clear keeps it running.
// [RULE_03] With the internal clock, gate accumulation counts only while the gate input is high.
// [RULE_04] Gate accumulation is ignored when the external pin clock is selected.
// [RULE_05] The prescale field divides the input by 1, 8, 64 or 256 for codes 00 to 11.
// [RULE_06] The pair-mode bit in the lower control register joins both timers into 32 bits.
// [RULE_07] With pair mode clear, the timers run independently from their own registers.
// [RULE_08] Clock source one counts rising pin edges; zero counts the peripheral clock.
// [RULE_09] In pair mode the upper run, gate, prescale and source bits have no effect.
// [RULE_10] Software keeps the upper idle-halt bit clear for the pair to run while idle.
// [RULE_11] Unimplemented control bits read as zero.
// [RULE_12] In pair mode the lower count is the low half and the upper count the high half.
// [RULE_13] In pair mode the lower inputs drive the pair and the upper flag signals its event.
// [RULE_14] Each tick increments; on period match the count clears and the flag is set.
`timescale 1ns/10ps
`include "ctp_consts.svh"
module ctp_top #(
    parameter int AW = 8
) (
    // Clock and reset
    input  logic          pclk,
    input  logic          presetn,
    // APB slave
    input  logic          psel,
    input  logic          penable,
    input  logic          pwrite,
    input  logic [AW-1:0] paddr,
    input  logic [31:0]   pwdata,
    output logic [31:0]   prdata,
    output logic          pready,
    output logic          pslverr,
    // Device power state
    input  logic          idle_mode,
    // Timer pins
    input  logic          lower_ext_clock_pin,
    input  logic          upper_ext_clock_pin,
    input  logic          lower_gate_pin,
    input  logic          upper_gate_pin,
    // Interrupt
    output logic          irq
);
    logic [15:0] lctrl_r;
    logic [15:0] uctrl_r;
    logic [15:0] lper_r;
    logic [15:0] uper_r;
    logic [1:0]  stat_r;
    logic [1:0]  stat_nxt;
    logic [1:0]  mask_r;
    logic [31:0] prdata_r;
    logic [15:0] lcnt;
    logic [15:0] ucnt;

    ctp_tick_if ltk ();
    ctp_tick_if utk ();

    // APB phase decode; every access completes with no wait state
    wire setup = psel & ~penable;
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;

    // Address decode
    wire hit_lctrl = (paddr == AW'(`CTP_OFF_LCTRL));
    wire hit_uctrl = (paddr == AW'(`CTP_OFF_UCTRL));
    wire hit_lcnt  = (paddr == AW'(`CTP_OFF_LCNT));
    wire hit_ucnt  = (paddr == AW'(`CTP_OFF_UCNT));
    wire hit_lper  = (paddr == AW'(`CTP_OFF_LPER));
    wire hit_uper  = (paddr == AW'(`CTP_OFF_UPER));
    wire hit_stat  = (paddr == AW'(`CTP_OFF_STAT));
    wire hit_mask  = (paddr == AW'(`CTP_OFF_MASK));
    wire mapped    = hit_lctrl | hit_uctrl | hit_lcnt | hit_ucnt |
                     hit_lper | hit_uper | hit_stat | hit_mask;

    // Read selection; control words carry only implemented bits
    wire [31:0] rd_mux =
        hit_lctrl ? {16'h0000, lctrl_r & `CTP_LCTRL_MASK} :         // [RULE_11]
        hit_uctrl ? {16'h0000, uctrl_r & `CTP_UCTRL_MASK} :         // [RULE_11]
        hit_lcnt  ? {16'h0000, lcnt}   :
        hit_ucnt  ? {16'h0000, ucnt}   :
        hit_lper  ? {16'h0000, lper_r} :
        hit_uper  ? {16'h0000, uper_r} :
        hit_stat  ? {30'h0000_0000, stat_r} :
        hit_mask  ? {30'h0000_0000, mask_r} : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_r;

    // Mode selection: only the lower register can join the pair
    wire pair = lctrl_r[`CTP_BIT_PAIR];                              // [RULE_06]

    // Idle halt; in pair mode a set upper idle bit also stops the pair
    wire l_halt = idle_mode & (lctrl_r[`CTP_BIT_IDLE] |
                  (pair & uctrl_r[`CTP_BIT_IDLE]));                  // [RULE_02] [RULE_10]
    wire u_halt = idle_mode & uctrl_r[`CTP_BIT_IDLE];                // [RULE_02]
    wire l_active = lctrl_r[`CTP_BIT_RUN] & ~l_halt;                 // [RULE_01]
    // Upper timer's run, gate, prescale and source controls are dead while paired
    wire u_active = ~pair & uctrl_r[`CTP_BIT_RUN] & ~u_halt;         // [RULE_07] [RULE_09]

    // Lower input path always from lower register and pins
    assign ltk.active  = l_active;
    assign ltk.css     = lctrl_r[`CTP_BIT_CSS];
    assign ltk.gate_en = lctrl_r[`CTP_BIT_GATE];
    assign ltk.gate    = lower_gate_pin;                             // [RULE_13]
    assign ltk.ext_pin = lower_ext_clock_pin;                        // [RULE_13]
    assign ltk.presc   = ctp_pkg::ctp_presc_t'(lctrl_r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]);

    // Upper input path, used only as an independent timer
    assign utk.active  = u_active;
    assign utk.css     = uctrl_r[`CTP_BIT_CSS];
    assign utk.gate_en = uctrl_r[`CTP_BIT_GATE];
    assign utk.gate    = upper_gate_pin;
    assign utk.ext_pin = upper_ext_clock_pin;
    assign utk.presc   = ctp_pkg::ctp_presc_t'(uctrl_r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]);

    // One prescaler per timer
    ctp_prescaler u_lpre (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (ltk)
    );

    ctp_prescaler u_upre (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (utk)
    );

    // Period match, 16-bit each or 32-bit joined
    wire l_match16 = (lcnt == lper_r);
    wire u_match16 = (ucnt == uper_r);
    wire match32   = l_match16 & u_match16;                          // [RULE_12]
    wire l_evt     = ltk.tick & (pair ? match32 : l_match16);        // [RULE_14]
    wire u_evt     = utk.tick & u_match16;                           // [RULE_14]

    // Upper half advances on the lower half's rollover when paired
    wire carry  = ltk.tick & (lcnt == `CTP_CNT_MAX) & ~match32;      // [RULE_12]
    wire u_inc  = pair ? carry : utk.tick;                           // [RULE_07] [RULE_12]
    wire u_clr  = pair ? l_evt : u_evt;

    // Counter write strobes
    wire wr_lcnt = wr & hit_lcnt;
    wire wr_ucnt = wr & hit_ucnt;

    ctp_counter #(.W(16)) u_lcnt (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ltk.tick),
        .clr     (l_evt),
        .wr_en   (wr_lcnt),
        .wr_data (pwdata[15:0]),
        .count   (lcnt)
    );

    ctp_counter #(.W(16)) u_ucnt (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (u_inc),
        .clr     (u_clr),
        .wr_en   (wr_ucnt),
        .wr_data (pwdata[15:0]),
        .count   (ucnt)
    );

    // Event flags: paired event lands on the upper flag only
    wire [1:0] ev_set;
    assign ev_set[`CTP_IRQ_LOWER] = ~pair & l_evt;                   // [RULE_13]
    assign ev_set[`CTP_IRQ_UPPER] = pair ? l_evt : u_evt;            // [RULE_13] [RULE_14]
    wire [1:0] st_clr = (wr & hit_stat) ? pwdata[1:0] : 2'h0;
    // A set in the same cycle as a write-one-to-clear wins
    assign stat_nxt = (stat_r & ~st_clr) | ev_set;

    assign irq = |(stat_r & mask_r);

    // Control registers; unimplemented bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lctrl_r <= `CTP_CTRL_RST;
            uctrl_r <= `CTP_CTRL_RST;
        end else begin
            if (wr && hit_lctrl) begin
                lctrl_r <= pwdata[15:0] & `CTP_LCTRL_MASK;           // [RULE_11]
            end
            if (wr && hit_uctrl) begin
                uctrl_r <= pwdata[15:0] & `CTP_UCTRL_MASK;           // [RULE_11]
            end
        end
    end

    // Period registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lper_r <= `CTP_PERIOD_RST;
            uper_r <= `CTP_PERIOD_RST;
        end else begin
            if (wr && hit_lper) begin
                lper_r <= pwdata[15:0];
            end
            if (wr && hit_uper) begin
                uper_r <= pwdata[15:0];
            end
        end
    end

    // Status and mask registers; read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r   <= 2'h0;
            mask_r   <= 2'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            stat_r <= stat_nxt;
            if (wr && hit_mask) begin
                mask_r <= pwdata[1:0];
            end
            if (setup) begin
                prdata_r <= rd_mux;
            end
        end
    end

    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
        (setup && hit_lctrl) |=> ((prdata_r & ~32'h0000_A07A) == 32'h0000_0000))
        else $error("unimplemented lower control bit read nonzero");

    a_run_stops: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
        (!lctrl_r[`CTP_BIT_RUN] && !wr_lcnt) |=> (lcnt == $past(lcnt)))
        else $error("lower count moved while stopped");

    a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
        (idle_mode && lctrl_r[`CTP_BIT_IDLE] && !wr_lcnt) |=> (lcnt == $past(lcnt)))
        else $error("lower count moved in idle with halt set");

    a_gate_block: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
        (!lctrl_r[`CTP_BIT_CSS] && lctrl_r[`CTP_BIT_GATE] && !lower_gate_pin) |-> !ltk.tick)
        else $error("tick while gate closed");

    a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08] [RULE_04]
        (lctrl_r[`CTP_BIT_CSS] && ltk.tick)
        |-> (lower_ext_clock_pin && !$past(lower_ext_clock_pin)))
        else $error("external tick without rising pin edge");

    a_pair_ignore: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
        pair |-> !utk.tick)
        else $error("upper prescaler ticked in pair mode");

    a_pair_carry: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
        (pair && carry && !wr_ucnt) |=> (ucnt == 16'($past(ucnt) + 16'h0001)))
        else $error("upper half missed lower rollover");

    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13] [RULE_14]
        (pair && l_evt && !wr_lcnt && !wr_ucnt)
        |=> (stat_r[`CTP_IRQ_UPPER] && lcnt == 16'h0000 && ucnt == 16'h0000))
        else $error("paired match did not clear or flag");

    // Flag paths: each timer sets only its own bit, the pair only the upper one
    a_lower_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        (!pair && l_evt) |=> stat_r[`CTP_IRQ_LOWER])
        else $error("lower match did not set its flag");

    a_upper_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07] [RULE_14]
        (!pair && u_evt) |=> stat_r[`CTP_IRQ_UPPER])
        else $error("upper match did not set its flag");

    a_pair_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
        (pair && !stat_r[`CTP_IRQ_LOWER]) |=> !stat_r[`CTP_IRQ_LOWER])
        else $error("paired timer set the lower flag");

    // A clear that meets no new event must really drop the flag
    a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        (wr && hit_stat && pwdata[`CTP_IRQ_LOWER] && !ev_set[`CTP_IRQ_LOWER])
        |=> !stat_r[`CTP_IRQ_LOWER])
        else $error("lower flag survived a write of one");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
        (stat_r[`CTP_IRQ_UPPER] && mask_r[`CTP_IRQ_UPPER]) |-> irq)
        else $error("unmasked upper flag without interrupt");

    // Upper half: moves only on a carry or a paired match when paired, only on its own tick otherwise
    a_pair_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12] [RULE_09]
        (pair && !carry && !l_evt && !wr_ucnt) |=> (ucnt == $past(ucnt)))
        else $error("upper half moved without a carry");

    a_upper_stopped: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
        (!pair && !uctrl_r[`CTP_BIT_RUN] && !wr_ucnt) |=> (ucnt == $past(ucnt)))
        else $error("upper count moved while stopped");

    a_upper_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
        (!pair && !uctrl_r[`CTP_BIT_CSS] && uctrl_r[`CTP_BIT_GATE] && !upper_gate_pin)
        |-> !utk.tick)
        else $error("upper tick while its gate closed");

    // A period write must land intact, since every lower and paired match compares against it
    a_period_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        (wr && hit_lper) |=> (lper_r == $past(pwdata[15:0])))
        else $error("lower period write lost");
endmodule // ctp_top

// *** testbench/ctp_pins_model.sv ***
`timescale 1ns/10ps
// Pin-side stand-in: external timer clocks and gate levels
module ctp_pins_model #(
    parameter int HALF = 3
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Requests from the bench
    input  wire logic clk_en,
    input  wire logic lgate,
    input  wire logic ugate,
    // Timer pins
    output logic      lower_ext_clock_pin,
    output logic      upper_ext_clock_pin,
    output logic      lower_gate_pin,
    output logic      upper_gate_pin
);
    int div_r;

    // Pin clock stands low while disabled, so no stray edge is ever counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 0;
            lower_ext_clock_pin <= 1'b0;
        end else if (!clk_en) begin
            div_r <= 0;
            lower_ext_clock_pin <= 1'b0;
        end else if (div_r == HALF - 1) begin
            div_r <= 0;
            lower_ext_clock_pin <= !lower_ext_clock_pin; // One rise per 2*HALF cycles
        end else begin
            div_r <= div_r + 1;
        end
    end

    // Upper clock runs in opposite phase; gates are plain levels
    assign upper_ext_clock_pin = clk_en & !lower_ext_clock_pin;
    assign lower_gate_pin      = lgate;
    assign upper_gate_pin      = ugate;
endmodule // ctp_pins_model

// *** testbench/cascadable_timer_pair_test.sv ***
`timescale 1ns/10ps
`include "ctp_consts.svh"
module cascadable_timer_pair_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_mode = 1'b0;
    logic        clk_en = 1'b0;
    logic        lgate = 1'b0;
    logic        lck, uck, lgp, ugp, irq, err;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // 10 MHz peripheral clock
    always #50 pclk = ~pclk;

    ctp_top #(.AW(8)) u_ctp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
        .lower_ext_clock_pin(lck), .upper_ext_clock_pin(uck), .lower_gate_pin(lgp),
        .upper_gate_pin(ugp), .irq(irq));

    ctp_pins_model #(.HALF(3)) u_ctp_pins_model (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .lgate(lgate), .ugate(1'b0), .lower_ext_clock_pin(lck),
        .upper_ext_clock_pin(uck), .lower_gate_pin(lgp), .upper_gate_pin(ugp));

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            conclude();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so psel is never driven twice in one time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0000_0000, q);
    endtask

    // Count advance between two reads whose setup edges are gap+3 cycles apart
    task automatic measure(input logic [7:0] ca, input logic [15:0] cv, input logic [7:0] na,
                           input int gap, output logic [31:0] diff);
        logic [31:0] a, b;
        wr(ca, {16'h0000, cv});
        repeat (300) @(posedge pclk);
        rd(na, a);
        repeat (gap) @(posedge pclk);
        rd(na, b);
        diff = {16'h0000, b[15:0] - a[15:0]};
    endtask

    task automatic t_regs();
        logic [31:0] q;
        rd(`CTP_OFF_LPER, q);
        check(q, 32'h0000_FFFF);
        wr(`CTP_OFF_LCTRL, 32'hFFFF_FFFF);
        rd(`CTP_OFF_LCTRL, q);
        check(q, 32'h0000_A07A);
        wr(`CTP_OFF_UCTRL, 32'hFFFF_FFFF);
        rd(`CTP_OFF_UCTRL, q);
        check(q, 32'h0000_A072);
        wr(`CTP_OFF_LCTRL, 32'h0000_0000);
        wr(`CTP_OFF_UCTRL, 32'h0000_0000);
        rd(8'h20, q);
        check({31'h0, err}, 32'h1);
    endtask

    task automatic t_prescale();
        logic [31:0] d;
        int          div [4] = '{1, 8, 64, 256};
        for (int c = 0; c < 4; c++) begin
            measure(`CTP_OFF_LCTRL, 16'h8000 | 16'(c << 4), `CTP_OFF_LCNT, 4 * div[c] - 3, d);
            check(d, 32'h4);
        end
    endtask

    task automatic t_independent();
        logic [31:0] d;
        measure(`CTP_OFF_LCTRL, 16'h0000, `CTP_OFF_LCNT, 2, d);
        check(d, 32'h0);
        measure(`CTP_OFF_UCTRL, 16'h8000, `CTP_OFF_UCNT, 1, d);
        check(d, 32'h4);
        measure(`CTP_OFF_UCTRL, 16'h8010, `CTP_OFF_UCNT, 29, d);
        check(d, 32'h4);
        measure(`CTP_OFF_UCTRL, 16'h8040, `CTP_OFF_UCNT, 1, d);
        check(d, 32'h0);
        wr(`CTP_OFF_UCTRL, 32'h0000_0000);
    endtask

    task automatic t_gate_source_idle();
        logic [31:0] d;
        measure(`CTP_OFF_LCTRL, 16'h8040, `CTP_OFF_LCNT, 6, d);
        check(d, 32'h0);
        lgate <= 1'b1;
        measure(`CTP_OFF_LCTRL, 16'h8040, `CTP_OFF_LCNT, 5, d);
        check(d, 32'h8);
        lgate <= 1'b0;
        clk_en <= 1'b1;
        measure(`CTP_OFF_LCTRL, 16'h8042, `CTP_OFF_LCNT, 9, d);
        check(d, 32'h2);
        clk_en <= 1'b0;
        idle_mode <= 1'b1;
        measure(`CTP_OFF_LCTRL, 16'hA000, `CTP_OFF_LCNT, 6, d);
        check(d, 32'h0);
        measure(`CTP_OFF_LCTRL, 16'h8000, `CTP_OFF_LCNT, 5, d);
        check(d, 32'h8);
        idle_mode <= 1'b0;
    endtask

    task automatic t_pair_carry();
        logic [31:0] q;
        wr(`CTP_OFF_LCTRL, 32'h0000_0000);
        // Upper settings would freeze it; idle halt kept clear for the pair
        wr(`CTP_OFF_UCTRL, 32'h0000_0072);
        wr(`CTP_OFF_LCNT, 32'h0000_FFFE);
        wr(`CTP_OFF_UCNT, 32'h0000_0005);
        wr(`CTP_OFF_LCTRL, 32'h0000_8008);
        repeat (6) @(posedge pclk);
        wr(`CTP_OFF_LCTRL, 32'h0000_0008);
        rd(`CTP_OFF_UCNT, q);
        check(q, 32'h0000_0006);
    endtask

    task automatic t_pair_irq();
        logic [31:0] q;
        int          n;
        wr(`CTP_OFF_LPER, 32'h0000_0003);
        wr(`CTP_OFF_UPER, 32'h0000_0000);
        wr(`CTP_OFF_LCNT, 32'h0000_0000);
        wr(`CTP_OFF_UCNT, 32'h0000_0000);
        wr(`CTP_OFF_MASK, 32'h0000_0002);
        wr(`CTP_OFF_LCTRL, 32'h0000_8008);
        n = 0;
        while (irq !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, n >= 50}, 32'h0);
        if (n >= 50) conclude();
        wr(`CTP_OFF_LCTRL, 32'h0000_0008);
        rd(`CTP_OFF_STAT, q);
        check(q, 32'h0000_0002);
        rd(`CTP_OFF_UCNT, q);
        check(q, 32'h0000_0000);
        rd(`CTP_OFF_LCNT, q);
        check({31'h0, q < 4}, 32'h1);
        wr(`CTP_OFF_MASK, 32'h0000_0000);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        @(posedge pclk);
        wr(`CTP_OFF_MASK, 32'h0000_0002);
        @(negedge pclk);
        check({31'h0, irq}, 32'h1);
        @(posedge pclk);
        wr(`CTP_OFF_STAT, 32'h0000_0002);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        @(posedge pclk);
        rd(`CTP_OFF_STAT, q);
        check(q, 32'h0000_0000);
    endtask

    // Independent timers each raise their own flag; then clear one flag alone
    task automatic t_lower_irq();
        logic [31:0] q;
        wr(`CTP_OFF_LCTRL, 32'h0000_0000);
        wr(`CTP_OFF_LPER, 32'h0000_0002);
        wr(`CTP_OFF_LCNT, 32'h0000_0000);
        wr(`CTP_OFF_MASK, 32'h0000_0001);
        wr(`CTP_OFF_UCTRL, 32'h0000_8000);
        wr(`CTP_OFF_LCTRL, 32'h0000_8010);
        repeat (30) @(posedge pclk);
        wr(`CTP_OFF_LCTRL, 32'h0000_0000);
        wr(`CTP_OFF_UCTRL, 32'h0000_0000);
        rd(`CTP_OFF_STAT, q);
        check(q, 32'h0000_0003);
        check({31'h0, irq}, 32'h1);
        rd(`CTP_OFF_LCNT, q);
        check({31'h0, q < 3}, 32'h1);
        wr(`CTP_OFF_STAT, 32'h0000_0001);
        rd(`CTP_OFF_STAT, q);
        check(q, 32'h0000_0002);
        check({31'h0, irq}, 32'h0);
    endtask

    // Reset for four cycles, then every scenario in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_prescale();
        t_independent();
        t_gate_source_idle();
        t_pair_carry();
        t_pair_irq();
        t_lower_irq();
        conclude();
    end
endmodule // cascadable_timer_pair_test
